// File: verilog/mst_defs.vh
// register map, field positions and reset values of the strobe timing block
`ifndef MST_DEFS_VH
`define MST_DEFS_VH

`define MST_ADDR_W        6
// word addresses: 0x00..0x0f strobe words (bank*4 + strobe)
`define MST_ADDR_STROBE   6'h00
`define MST_ADDR_BANK1    6'h10
`define MST_ADDR_CTRL     6'h14
`define MST_ADDR_STATUS   6'h15

// strobe numbers inside a bank
`define MST_STB_ROW       0
`define MST_STB_COL       1
`define MST_STB_PROG      2
`define MST_STB_WRITE     3

// strobe timing word
`define MST_SW_W          17
`define MST_SW_FALL_LO    0
`define MST_SW_FALL_HI    5
`define MST_SW_RISE_LO    6
`define MST_SW_RISE_HI    11
`define MST_SW_FALL_DEF   12
`define MST_SW_RISE_DEF   13
`define MST_SW_QUAL_RD    14
`define MST_SW_QUAL_WR    15
`define MST_SW_ACTIVE     16
`define MST_SW_RESET      17'h0_0000

// bank_config_word_one
`define MST_B1_W          14
`define MST_B1_WAIT       0
`define MST_B1_DRAM       1
`define MST_B1_ROW_LO     8
`define MST_B1_ROW_HI     13
`define MST_B1_RESET      14'h0000

// global control word: pending_select_bit
`define MST_CTRL_PEND     0

// phase counting: two phases per clock, counter saturates
`define MST_PH_W          7
`define MST_PH_PER_CLK    7'h02
`define MST_PH_MAX        7'h7e

`endif

// File: verilog/mst_edge_unit.v
// one strobe's falling and rising edge decision for the current cycle
`timescale 1ns/1ps
module mst_edge_unit #(
	parameter IS_ROW   = 0,
	parameter IS_WRITE = 0
) (
	input  wire [16:0] cfg,
	input  wire        busy,
	input  wire        is_write,
	input  wire        is_dram,
	input  wire [5:0]  row_edge,
	input  wire [6:0]  cyc_ph,
	input  wire [6:0]  cas_ph,
	input  wire        cas_on,
	output reg         strobe_low
);
`include "mst_defs.vh"

	reg        row_timed;
	reg        ref_ok;
	reg  [6:0] ph;
	reg  [5:0] fall;
	reg        rise_en;
	reg  [1:0] qual;

	always @* begin
		qual = {cfg[`MST_SW_QUAL_WR], cfg[`MST_SW_QUAL_RD]};
		// row strobe of a dram bank without its own fall delay follows
		// the bank's row edge setting, counted from cycle start
		row_timed = (IS_ROW != 0) && is_dram && !cfg[`MST_SW_FALL_DEF];
		if (is_dram && !row_timed) begin
			ph     = cas_ph;
			ref_ok = cas_on;
		end else begin
			ph     = cyc_ph;
			ref_ok = 1'b1;
		end
		if (row_timed)
			fall = row_edge;
		else if (cfg[`MST_SW_FALL_DEF])
			fall = cfg[`MST_SW_FALL_HI:`MST_SW_FALL_LO];
		else
			fall = 6'h00;
		if (qual != 2'b00)
			rise_en = is_write ? qual[1] : qual[0];
		else if (IS_WRITE != 0)
			rise_en = is_write;
		else
			rise_en = 1'b1;
		// no rise programmed, or rise not qualified: low until cycle end
		strobe_low = busy && cfg[`MST_SW_ACTIVE] && ref_ok &&
			(ph >= {1'b0, fall}) &&
			!(cfg[`MST_SW_RISE_DEF] && rise_en &&
			  (ph >= {1'b0, cfg[`MST_SW_RISE_HI:`MST_SW_RISE_LO]}));
	end

endmodule // mst_edge_unit

// File: verilog/mst_strobe_timing.v
// programmable memory strobe timing with register port and pending pin
// Operation
// - a strobe rises early only in cycle types its qualifier selects
// - no qualifier: rise in reads and writes; write strobe in writes only
// - pending select 1 shows dma cycle pending, 0 shows refresh pending
// - strobe falls after 0..63 phases, from cas start or cycle start
// - optional rise delay 0..63 phases, same reference as the fall
// - without rise delay the strobe stays low until cycle end
// - wait input stretches timing only in banks with wait gate set
// - the bank's write strobe timing drives all four byte enables
// - bank without write strobe keeps byte enables inactive
// - two phases per clock; cycle counts are even phase counts
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module mst_strobe_timing #(
	parameter BANKS = 4
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire [5:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	input  wire        cycle_start,
	input  wire [1:0]  cycle_bank,
	input  wire        cycle_write,
	input  wire        cas_start,
	input  wire        cycle_end,
	input  wire        external_wait_in,
	input  wire        dma_cycle_pending,
	input  wire        refresh_pending,
	output reg         row_strobe_n,
	output reg         col_strobe_n,
	output reg         prog_strobe_n,
	output reg  [3:0]  byte_enable_n,
	output reg         pending_indicator_out
);
`include "mst_defs.vh"

	reg  [16:0] strobe_cfg [0:15];
	reg  [13:0] bank_config_word_one [0:3];
	reg         pending_select_bit;

	reg         busy_reg;
	reg  [1:0]  bank_reg;
	reg         write_reg;
	reg  [6:0]  cyc_ph_reg;
	reg  [6:0]  cas_ph_reg;
	reg         cas_on_reg;

	wire [3:0]  low_req;
	wire [13:0] cur_b1;
	wire        stall;
	reg  [31:0] rdata_next;
	integer     i;

	assign cur_b1 = bank_config_word_one[bank_reg];
	// wait only freezes the phase count of gated banks
	assign stall = external_wait_in && cur_b1[`MST_B1_WAIT];

	// register writes
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (i = 0; i < 16; i = i + 1)
				strobe_cfg[i] <= `MST_SW_RESET;
			for (i = 0; i < 4; i = i + 1)
				bank_config_word_one[i] <= `MST_B1_RESET;
			pending_select_bit <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr[5:4] == 2'b00)
				strobe_cfg[reg_addr[3:0]] <= reg_wdata[16:0];
			else if (reg_addr[5:2] == 4'h4)
				bank_config_word_one[reg_addr[1:0]] <=
					reg_wdata[13:0];
			else if (reg_addr == `MST_ADDR_CTRL)
				pending_select_bit <= reg_wdata[`MST_CTRL_PEND];
		end
	end

	// read mux; data stands the cycle after the strobe, zero otherwise
	always @* begin
		rdata_next = 32'h0000_0000;
		if (reg_addr[5:4] == 2'b00)
			rdata_next = {15'h0000, strobe_cfg[reg_addr[3:0]]};
		else if (reg_addr[5:2] == 4'h4)
			rdata_next = {18'h0_0000,
				bank_config_word_one[reg_addr[1:0]]};
		else if (reg_addr == `MST_ADDR_CTRL)
			rdata_next = {31'h0000_0000, pending_select_bit};
		else if (reg_addr == `MST_ADDR_STATUS)
			rdata_next = {15'h0000, busy_reg, bank_reg, write_reg,
				cas_on_reg, stall, row_strobe_n, col_strobe_n,
				prog_strobe_n, byte_enable_n[0], cyc_ph_reg};
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= 32'h0000_0000;
	end

	// memory cycle tracking and phase counters
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_reg   <= 1'b0;
			bank_reg   <= 2'b00;
			write_reg  <= 1'b0;
			cyc_ph_reg <= 7'h00;
			cas_ph_reg <= 7'h00;
			cas_on_reg <= 1'b0;
		end else if (cycle_start) begin
			busy_reg   <= 1'b1;
			bank_reg   <= cycle_bank;
			write_reg  <= cycle_write;
			cyc_ph_reg <= 7'h00;
			cas_ph_reg <= 7'h00;
			cas_on_reg <= 1'b0;
		end else if (cycle_end) begin
			busy_reg   <= 1'b0;
			cas_on_reg <= 1'b0;
		end else if (busy_reg) begin
			if (cas_start) begin
				cas_on_reg <= 1'b1;
				cas_ph_reg <= 7'h00;
			end else if (cas_on_reg && !stall &&
					cas_ph_reg < `MST_PH_MAX) begin
				cas_ph_reg <= cas_ph_reg + `MST_PH_PER_CLK;
			end
			// saturate so a long cycle never wraps back under a delay
			if (!stall && cyc_ph_reg < `MST_PH_MAX)
				cyc_ph_reg <= cyc_ph_reg + `MST_PH_PER_CLK;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : stb
			mst_edge_unit #(
				.IS_ROW   (g == `MST_STB_ROW),
				.IS_WRITE (g == `MST_STB_WRITE)
			) u_edge (
				// word index bank*4 + strobe, without a genvar bit-select
				.cfg        (strobe_cfg[bank_reg * 4 + g]),
				.busy       (busy_reg),
				.is_write   (write_reg),
				.is_dram    (cur_b1[`MST_B1_DRAM]),
				.row_edge   (cur_b1[`MST_B1_ROW_HI:`MST_B1_ROW_LO]),
				.cyc_ph     (cyc_ph_reg),
				.cas_ph     (cas_ph_reg),
				.cas_on     (cas_on_reg),
				.strobe_low (low_req[g])
			);
		end
	endgenerate

	// strobe pins and pending pin, registered
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			row_strobe_n          <= 1'b1;
			col_strobe_n          <= 1'b1;
			prog_strobe_n         <= 1'b1;
			byte_enable_n         <= 4'hf;
			pending_indicator_out <= 1'b0;
		end else begin
			row_strobe_n  <= ~low_req[`MST_STB_ROW];
			col_strobe_n  <= ~low_req[`MST_STB_COL];
			prog_strobe_n <= ~low_req[`MST_STB_PROG];
			// inactive write strobe leaves all four high
			byte_enable_n <= {4{~low_req[`MST_STB_WRITE]}};
			pending_indicator_out <= pending_select_bit ?
				dma_cycle_pending : refresh_pending;
		end
	end

endmodule // mst_strobe_timing

// File: test/mst_strobe_monitor.sv
// port checker for the strobe timing block
`timescale 1ns/1ps
module mst_strobe_monitor (
	input wire		clk,
	input wire		sys_rst,
	input wire [5:0]	reg_addr,
	input wire [31:0]	reg_wdata,
	input wire		reg_wr,
	input wire		reg_rd,
	input wire [31:0]	reg_rdata,
	input wire		cycle_start,
	input wire [1:0]	cycle_bank,
	input wire		cycle_end,
	input wire		dma_cycle_pending,
	input wire		refresh_pending,
	input wire		row_strobe_n,
	input wire		col_strobe_n,
	input wire		prog_strobe_n,
	input wire [3:0]	byte_enable_n,
	input wire		pending_indicator_out
);
	reg		busy_q, sel, live;
	reg [1:0]	cb;
	reg [15:0]	act;
	wire		all_hi = row_strobe_n & col_strobe_n & prog_strobe_n
				& (&byte_enable_n);
	// shadow the active bits and the pending select bit; mid-cycle rewrites are not modelled
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{busy_q, sel, live, cb, act} <= 21'h00_0000;
		end else begin
			live <= 1'b1;
			if (cycle_start)
				{busy_q, cb} <= {1'b1, cycle_bank};
			else if (cycle_end)
				busy_q <= 1'b0;
			if (reg_wr && reg_addr == 6'h14)
				sel <= reg_wdata[0];
			if (reg_wr && reg_addr < 6'h10)
				act[reg_addr[3:0]] <= reg_wdata[16];
		end
	end
	default clocking dflt @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_quiet;
		!busy_q [*2];
	endsequence
	a_be_same: assert property (
		byte_enable_n == 4'h0 || byte_enable_n == 4'hf)
		else $error("byte enables differ");
	a_pend_sel: assert property (live && $past(live) |->
		pending_indicator_out ==
		$past(sel ? dma_cycle_pending : refresh_pending))
		else $error("pending pin wrong source");
	a_rd_zero: assert property (live && !$past(reg_rd) |->
		reg_rdata == 32'h0000_0000) else $error("read data not idle");
	a_idle_high: assert property (s_quiet |-> all_hi)
		else $error("strobe low outside a cycle");
	a_start_high: assert property (s_quiet ##0 cycle_start |=> all_hi)
		else $error("strobe low in first cycle");
	a_end_high: assert property (
		busy_q && cycle_end && !cycle_start |-> ##2 all_hi)
		else $error("strobe low after cycle end");
	a_row_inact: assert property (
		busy_q && !$past(cycle_start) && !act[{cb, 2'h0}] |-> row_strobe_n)
		else $error("inactive row strobe low");
	a_be_inact: assert property (
		busy_q && !$past(cycle_start) && !act[{cb, 2'h3}] |->
		byte_enable_n == 4'hf) else $error("inactive byte enables low");
endmodule // mst_strobe_monitor
bind mst_strobe_timing mst_strobe_monitor u_mst_strobe_monitor (.clk,
	.sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.cycle_start, .cycle_bank, .cycle_end, .dma_cycle_pending,
	.refresh_pending, .row_strobe_n, .col_strobe_n, .prog_strobe_n,
	.byte_enable_n, .pending_indicator_out);

// File: test/mst_mem_model.sv
// memory part model that asks for a wait when its strobe falls
`timescale 1ns/1ps
module mst_mem_model (
	input wire	clk,
	input wire	col_strobe_n,
	input wire	slow,
	output reg	external_wait_in = 1'b0
);
	reg col_q = 1'b1;
	// slow parts stretch one cycle; the bank gate decides if it counts
	always @(posedge clk) begin
		col_q <= col_strobe_n;
		external_wait_in <= slow & col_q & ~col_strobe_n;
	end
endmodule // mst_mem_model

// File: test/testbench.sv
// self-checking bench: register port, strobe timing, pending pin
`timescale 1ns/1ps
module testbench;
	reg clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, cycle_start = 0;
	reg cycle_write = 0, cycle_end = 0, dma_cycle_pending = 0, chk = 0;
	reg refresh_pending = 0, slow = 0, rdv = 0, sel;
	reg [1:0] cycle_bank = 2'h0;
	reg [5:0] reg_addr = 6'h00, fa, pf;
	reg [31:0] reg_wdata = 32'h0000_0000, d, e, g;
	reg [16:0] sc, sp, sw;
	wire [31:0] reg_rdata;
	wire [3:0] byte_enable_n;
	wire row_strobe_n, col_strobe_n, prog_strobe_n;
	wire pending_indicator_out, external_wait_in;
	int errors = 0, samples_checked = 0, ticks = 0, m, k;
	logic [31:0] q[$];
	mst_strobe_timing u_mst_strobe_timing (.clk, .sys_rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cycle_start, .cycle_bank,
		.cycle_write, .cas_start(1'b0), .cycle_end, .external_wait_in,
		.dma_cycle_pending, .refresh_pending, .row_strobe_n, .col_strobe_n,
		.prog_strobe_n, .byte_enable_n, .pending_indicator_out);
	mst_mem_model u_mst_mem_model (.clk, .col_strobe_n, .slow,
		.external_wait_in);
	initial forever #2.5 clk = ~clk;
	task summarize;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		ticks++;
		if (ticks == 2000) begin
			errors++;
			summarize;
		end
		if (rdv || chk) begin
			e = q.pop_front();
			g = rdv ? reg_rdata : {24'h00_0000, pending_indicator_out,
				row_strobe_n, col_strobe_n, prog_strobe_n, byte_enable_n};
			samples_checked++;
			if (g !== e) begin
				errors++;
				$display("[FAIL] %s exp %h seen %h", rdv ? "rdata" : "pins", e, g);
			end
		end
		rdv <= reg_rd;
	end
	task wr(input [5:0] a, input [31:0] v);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [5:0] a, input [31:0] v);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		q.push_back(v);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	// expected low level of one strobe in cycle k after cycle start
	function automatic bit lo(input [16:0] s, input iw, w, input int k);
		bit r;
		r = s[13] && (s[15:14] == 2'h0 ? (!iw || w) : (w ? s[15] : s[14]));
		return s[16] && k >= (s[5:0] + 1) / 2 + 2 && k <= 7
			&& (!r || k < (s[11:6] + 1) / 2 + 2);
	endfunction
	initial begin
		d = $urandom(32'h0000_077a);
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(6'h3f, 32'h0000_0000);
		for (m = 0; m < 8; m++) begin
			fa = $urandom % 6;
			pf = $urandom % 6;
			d = $urandom;
			sel = m[0];
			{dma_cycle_pending, refresh_pending, slow} <= d[2:0];
			// every active strobe gets a fall delay defined
			sc = {1'b1, m[1:0], 2'h3, fa + 6'h04, fa};
			sp = {5'h11, 6'h00, pf};
			sw = m[1:0] == 2'h3 ? 17'h0_0000 : {5'h13, 12'h080};
			wr({2'h0, m[1:0], 2'h1}, sc);
			wr({2'h0, m[1:0], 2'h2}, sp);
			wr({2'h0, m[1:0], 2'h3}, sw);
			wr(6'h14, sel);
			rd({2'h0, m[1:0], 2'h1}, sc);
			@(posedge clk);
			{cycle_start, cycle_bank, cycle_write} <= {1'b1, m[1:0], m[2]};
			for (k = 1; k <= 8; k++) begin
				@(posedge clk);
				{cycle_start, cycle_end, chk} <= {1'b0, k == 6, 1'b1};
				q.push_back({24'h00_0000, sel ? d[2] : d[1], 1'b1,
					~lo(sc, 0, m[2], k), ~lo(sp, 0, m[2], k),
					{4{~lo(sw, 1, m[2], k)}}});
			end
			@(posedge clk);
			chk <= 1'b0;
		end
		repeat (2) @(posedge clk);
		summarize;
	end
endmodule // testbench
